// *** rtl/fpicx_map.svh ***
// register indices, field positions, reset values and timing for the panel bank
`ifndef FPICX_MAP_SVH
`define FPICX_MAP_SVH

// sequencer port select: index port or data port
`define FPICX_PORT_INDEX        1'b0
`define FPICX_PORT_DATA         1'b1

// register indices seen through the data port
`define FPICX_IDX_ICON_Y_HIGH   8'h4C
`define FPICX_IDX_ICON_Y_LOW    8'h4D
`define FPICX_IDX_ICON_BASE     8'h4E
`define FPICX_IDX_PANEL_GAP     8'h4F
`define FPICX_IDX_FB_SIZE_LOW   8'h50
`define FPICX_IDX_FB_SIZE_HIGH  8'h51
`define FPICX_IDX_MOD_CONTROL   8'h52
`define FPICX_IDX_MOD_DUTY      8'h53
`define FPICX_IDX_HORIZ_CTRL    8'h54
`define FPICX_IDX_HORIZ_MODES   8'h55
`define FPICX_IDX_VERT_CTRL     8'h56
`define FPICX_NUM_REGS          11

// writable bits of each register; the rest read as zero
`define FPICX_MASK_ICON_Y_HIGH  8'h03
`define FPICX_MASK_FULL         8'hFF
`define FPICX_MASK_MOD_CONTROL  8'h73
`define FPICX_MASK_HORIZ_CTRL   8'h9F
`define FPICX_MASK_HORIZ_MODES  8'h1F
`define FPICX_MASK_VERT_CTRL    8'h1F

// reset value shared by every register of the bank
`define FPICX_RESET_VALUE       8'h00

// backlight modulator control fields
`define FPICX_MOD_ENABLE_BIT    0
`define FPICX_MOD_SOURCE_BIT    1
`define FPICX_MOD_PRESCALE_LSB  4
`define FPICX_MOD_PRESCALE_MSB  6

// horizontal compensation fields
`define FPICX_TEXT_LSB          0
`define FPICX_TEXT_MSB          1
`define FPICX_GFX_LSB           2
`define FPICX_GFX_MSB           3
`define FPICX_HCENTER_BIT       4
`define FPICX_LINEGFX_BIT       7

// per-mode horizontal enables
`define FPICX_NARROW_TEXT_BIT   0
`define FPICX_WIDE_TEXT_BIT     1
`define FPICX_LOW_GFX_BIT       2
`define FPICX_MID_GFX_BIT       3
`define FPICX_HIGH_GFX_BIT      4

// memory geometry: one unit is 8K bytes, 2 MByte boundary
`define FPICX_UNIT_SHIFT        13
`define FPICX_ADDR_WIDTH        23

// one modulation period in pre-divided source clocks
`define FPICX_PERIOD_STEPS      256
`define FPICX_DUTY_FULL         8'hFF

`endif

// *** rtl/fpicx_pkg.sv ***
// types shared by the panel bank and its modulator
package fpicx_pkg;

	// two-bit stretch field coding, text and graphics alike
	typedef enum logic [1:0] {
		FPICX_STRETCH_OFF      = 2'h0,
		FPICX_STRETCH_LIMITED  = 2'h1,
		FPICX_STRETCH_RESERVED = 2'h2,
		FPICX_STRETCH_FULL     = 2'h3
	} fpicx_stretch_t;

	// pre-divider codes of the backlight modulator
	typedef enum logic [2:0] {
		FPICX_PRE_DIV1   = 3'h0,
		FPICX_PRE_DIV1P5 = 3'h1,
		FPICX_PRE_DIV2   = 3'h2,
		FPICX_PRE_DIV3   = 3'h4
	} fpicx_prescale_t;

endpackage

// *** rtl/fpicx_pwm.sv ***
// backlight modulator: pre-divider and 256-step duty comparator
`timescale 1ns/1ps
`default_nettype none
`include "fpicx_map.svh"

module fpicx_pwm
	import fpicx_pkg::*;
(
	input  wire logic       sys_clk,    // system clock
	input  wire logic       rst,        // synchronous reset
	input  wire logic       enable,     // modulation allowed
	input  wire logic       src_tick,   // one pulse per source clock rising edge
	input  wire logic [2:0] prescale,   // pre-divider code
	input  wire logic [7:0] duty,       // high steps per period
	output logic            mod_out     // registered modulated level
);

	logic [1:0] phase_r;    // position inside a division group of two or three edges
	logic [1:0] phase_last; // last phase before the group wraps
	logic       step;       // one pre-divided source clock
	logic [7:0] count_r;    // position in the modulation period

	// divide-by-2 wraps after two source edges, the others after three
	always_comb
	begin
		if (prescale == FPICX_PRE_DIV2)
			phase_last = 2'h1;
		else
			phase_last = 2'h2;
	end

	// phase of the source clock inside its division group
	// a wrap test by >= recovers a phase left over from a code change
	always_ff @(posedge sys_clk)
	begin
		if (rst || !enable)
			phase_r <= 2'h0;
		else if (src_tick)
			phase_r <= (phase_r >= phase_last) ? 2'h0 : phase_r + 2'h1;
	end

	// prescale step select
	// div 1.5 steps on two edges of every three; reserved codes stop
	always_comb
	begin
		case (fpicx_prescale_t'(prescale))
			FPICX_PRE_DIV1:   step = src_tick;
			FPICX_PRE_DIV1P5: step = src_tick && (phase_r != 2'h1);
			FPICX_PRE_DIV2:   step = src_tick && (phase_r == 2'h0);
			FPICX_PRE_DIV3:   step = src_tick && (phase_r == 2'h0);
			default:          step = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst || !enable)
			count_r <= 8'h00;
		else if (step)
			count_r <= count_r + 8'h01;
	end

	// duty comparison, full value pinned high
	always_ff @(posedge sys_clk)
	begin
		if (rst || !enable)
			mod_out <= 1'b0;
		else if (duty == `FPICX_DUTY_FULL)
			mod_out <= 1'b1;
		else
			mod_out <= (count_r < duty);
	end

endmodule
`default_nettype wire

// *** rtl/fpicx_bank.sv ***
// panel icon, passive-panel, backlight and expansion register bank
//
// How it works
// - icon vertical position: two high, eight low
// - icon base in 8K units, 4MB above 2MB
// - map select picks contiguous icon map
// - passive data area gap of 8K units
// - sixteen-bit passive frame size from two bytes
// - modulator drives shared pin unless 512Kx32
// - source select: reference or bus clock
// - prescale codes 1, 1.5, 2, 3; rest reserved
// - one period is 256 pre-divided clocks
// - high time equals duty over 256
// - duty 00 low, FF high constantly
// - text stretch: off, 1.25 cap, full
// - full stretch on VGA forces 8-dot text
// - graphics stretch uses same two-bit coding
// - horizontal centering enable bit
// - line graphics bit: ninth dot background otherwise
// - per-mode stretch enables for five modes
// - per-mode enables need general stretch enabled
// - text vertical stretch: off, 480, full
`timescale 1ns/1ps
`default_nettype none
`include "fpicx_map.svh"

module fpicx_bank
	import fpicx_pkg::*;
(
	input  wire logic        sys_clk,            // 20 MHz system clock
	input  wire logic        rst,                // synchronous reset
	// indexed sequencer port
	input  wire logic        host_port_sel,      // 0 index, 1 data
	input  wire logic        host_wr,            // write strobe
	input  wire logic        host_rd,            // read strobe
	input  wire logic [7:0]  host_wdata,         // write byte
	output logic      [7:0]  host_rdata,         // registered read byte
	output logic             host_rdata_valid,   // read answer pulse
	// memory configuration and icon mode
	input  wire logic        mem_is_4mb,         // 4 MByte fitted
	input  wire logic        mem_is_512kx32,     // 512Kx32 memory type
	input  wire logic [22:0] mem_top_addr,       // top of video memory
	input  wire logic [2:0]  icon_map_select,    // icon map number
	// modulator source clock pins
	input  wire logic        ref_clk_pin,        // 14.31818 MHz reference
	input  wire logic        pci_clk_pin,        // bus clock
	// display mode of the current frame
	input  wire logic        text_mode,          // text, not graphics
	input  wire logic        vga_panel,          // panel is VGA class
	input  wire logic        narrow_text_mode,   // 40-character text
	input  wire logic        wide_text_mode,     // 80-character text
	input  wire logic        low_res_gfx_mode,   // 640-column graphics
	input  wire logic        mid_res_gfx_mode,   // 800-column graphics
	input  wire logic        high_res_gfx_mode,  // 1024-column graphics
	// icon and passive panel geometry
	output logic      [9:0]  icon_vert_pos,      // icon y coordinate
	output logic      [22:0] icon_map_addr,      // selected map byte address
	output logic      [22:0] passive_data_start, // passive data byte address
	output logic      [15:0] passive_fb_size,    // frame size in quadwords
	// shared modulator pin
	output logic             mod_pin_out,        // modulated level
	output logic             mod_pin_oe,         // high while driving
	// expansion controls
	output logic             horiz_stretch_on,   // horizontal stretch active
	output logic             horiz_stretch_cap,  // limited to 1.25
	output logic             horiz_center_on,    // centre horizontally
	output logic             force_8dot_text,    // 9-dot text shown as 8-dot
	output logic             line_gfx_on,        // line graphics codes
	output logic             ninth_dot_bg,       // ninth dot uses background
	output logic             vert_stretch_on,    // text vertical stretch
	output logic             vert_stretch_cap    // limited to 480 lines
);

	// size of one icon map in bytes; the icon mode register sets geometry
	parameter int ICON_MAP_BYTES = 1024;
	// source pins pass this many flops before use
	parameter int SYNC_STAGES    = 3;

	// refuse values the address arithmetic or the three-stage synchroniser cannot serve
	initial
	begin
		if (ICON_MAP_BYTES < 1 || ICON_MAP_BYTES > 8192)
			$error("icon map size must be 1 to 8192 bytes");
		if (SYNC_STAGES != 3)
			$error("source pin synchroniser needs three stages");
	end

	// register file, index range 4C..56
	logic [7:0] regs_r [0:`FPICX_NUM_REGS-1];
	logic [7:0] index_r;          // selected register index
	logic [7:0] offset;           // index relative to the bank base
	logic       in_bank;          // index hits this bank
	logic [7:0] wr_mask;          // writable bits of the hit register
	logic [7:0] rd_value;         // value presented to a read

	// index arithmetic, shared by read and write
	always_comb
	begin
		offset  = index_r - `FPICX_IDX_ICON_Y_HIGH;
		in_bank = (index_r >= `FPICX_IDX_ICON_Y_HIGH) &&
		          (index_r <= `FPICX_IDX_VERT_CTRL);
	end

	// writable bit mask per register
	// reserved bits are never stored, so they read back as zero
	always_comb
	begin
		case (index_r)
			`FPICX_IDX_ICON_Y_HIGH: wr_mask = `FPICX_MASK_ICON_Y_HIGH;
			`FPICX_IDX_MOD_CONTROL: wr_mask = `FPICX_MASK_MOD_CONTROL;
			`FPICX_IDX_HORIZ_CTRL:  wr_mask = `FPICX_MASK_HORIZ_CTRL;
			`FPICX_IDX_HORIZ_MODES: wr_mask = `FPICX_MASK_HORIZ_MODES;
			`FPICX_IDX_VERT_CTRL:   wr_mask = `FPICX_MASK_VERT_CTRL;
			default:                wr_mask = `FPICX_MASK_FULL;
		endcase
	end

	// index port holds the register number for the data port
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			index_r <= 8'h00;
		else if (host_wr && host_port_sel == `FPICX_PORT_INDEX)
			index_r <= host_wdata;
	end

	// data port writes store the masked byte
	// writes to indices outside the bank are ignored here
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			for (int i = 0; i < `FPICX_NUM_REGS; i++)
				regs_r[i] <= `FPICX_RESET_VALUE;
		end
		else if (host_wr && host_port_sel == `FPICX_PORT_DATA && in_bank)
			regs_r[offset[3:0]] <= host_wdata & wr_mask;
	end

	// read source: index itself, a bank register, or zero
	always_comb
	begin
		if (host_port_sel == `FPICX_PORT_INDEX)
			rd_value = index_r;
		else if (in_bank)
			rd_value = regs_r[offset[3:0]];
		else
			rd_value = 8'h00;
	end

	// registered read answer, one cycle after the strobe
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			host_rdata       <= 8'h00;
			host_rdata_valid <= 1'b0;
		end
		else
		begin
			host_rdata_valid <= host_rd;
			if (host_rd)
				host_rdata <= rd_value;
		end
	end

	// named views of the stored registers
	logic [7:0] y_high, y_low, icon_base, gap, size_lo, size_hi;
	logic [7:0] mod_ctrl, mod_duty, horiz_ctrl, horiz_modes, vert_ctrl;

	always_comb
	begin
		y_high      = regs_r[0];
		y_low       = regs_r[1];
		icon_base   = regs_r[2];
		gap         = regs_r[3];
		size_lo     = regs_r[4];
		size_hi     = regs_r[5];
		mod_ctrl    = regs_r[6];
		mod_duty    = regs_r[7];
		horiz_ctrl  = regs_r[8];
		horiz_modes = regs_r[9];
		vert_ctrl   = regs_r[10];
	end

	// geometry words
	logic [22:0] base_bytes;      // icon base as a byte address
	logic [22:0] map_offset;      // offset of the chosen map
	logic [22:0] gap_bytes;       // reserved gap in bytes

	// base in 8K units, lifted past 2 MByte on 4 MByte parts
	// maps are contiguous above the base
	// gap counted down from the top of memory
	always_comb
	begin
		base_bytes = {1'b0, mem_is_4mb, icon_base, 13'h0000};
		map_offset = `FPICX_ADDR_WIDTH'(icon_map_select) *
		             `FPICX_ADDR_WIDTH'(ICON_MAP_BYTES);
		gap_bytes  = {2'h0, gap, 13'h0000};
	end

	// geometry outputs held in flops
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			icon_vert_pos      <= 10'h000;
			icon_map_addr      <= 23'h000000;
			passive_data_start <= 23'h000000;
			passive_fb_size    <= 16'h0000;
		end
		else
		begin
			icon_vert_pos      <= {y_high[1:0], y_low};
			icon_map_addr      <= base_bytes + map_offset;
			// software must keep the gap inside the memory fitted
			passive_data_start <= mem_top_addr - gap_bytes;
			// the value itself is the software's to compute
			passive_fb_size    <= {size_hi, size_lo};
		end
	end

	// source pin synchronisers; first stage feeds only the second
	logic [2:0] ref_sync_r, pci_sync_r;   // three-stage shift chains
	logic       ref_level_r, pci_level_r; // agreed level of each pin

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			ref_sync_r <= 3'h0;
			pci_sync_r <= 3'h0;
		end
		else
		begin
			ref_sync_r <= {ref_sync_r[1:0], ref_clk_pin};
			pci_sync_r <= {pci_sync_r[1:0], pci_clk_pin};
		end
	end

	// a level counts once the second and third stages agree
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			ref_level_r <= 1'b0;
			pci_level_r <= 1'b0;
		end
		else
		begin
			if (ref_sync_r[1] == ref_sync_r[2])
				ref_level_r <= ref_sync_r[2];
			if (pci_sync_r[1] == pci_sync_r[2])
				pci_level_r <= pci_sync_r[2];
		end
	end

	logic ref_rise, pci_rise;   // rising edge of each agreed level
	logic src_tick;             // rising edge of the selected source
	logic mod_enable;           // modulation allowed on this memory
	logic mod_level;            // modulator output

	// source clock select
	// sampling at 20 MHz only tracks sources well below that rate
	always_comb
	begin
		ref_rise = ref_sync_r[2] && ref_sync_r[1] && !ref_level_r;
		pci_rise = pci_sync_r[2] && pci_sync_r[1] && !pci_level_r;
		src_tick = mod_ctrl[`FPICX_MOD_SOURCE_BIT] ? pci_rise : ref_rise;
		mod_enable = mod_ctrl[`FPICX_MOD_ENABLE_BIT] && !mem_is_512kx32;
	end

	// modulator core
	fpicx_pwm u_pwm (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.enable   (mod_enable),
		.src_tick (src_tick),
		.prescale (mod_ctrl[`FPICX_MOD_PRESCALE_MSB:`FPICX_MOD_PRESCALE_LSB]),
		.duty     (mod_duty),
		.mod_out  (mod_level)
	);

	// shared pin drive
	// the pin is released entirely on 512Kx32 memory
	always_comb
	begin
		mod_pin_oe  = mod_enable;
		mod_pin_out = mod_enable && mod_level;
	end

	// expansion decode
	fpicx_stretch_t text_h, gfx_h, text_v;
	logic           mode_has_own;   // current mode has a per-mode bit
	logic           mode_own_bit;   // that per-mode bit
	logic           general_on;     // general field enables stretch
	logic           general_cap;    // general field limits stretch

	// field coding, reserved treated as off
	always_comb
	begin
		text_h = fpicx_stretch_t'(horiz_ctrl[`FPICX_TEXT_MSB:`FPICX_TEXT_LSB]);
		gfx_h  = fpicx_stretch_t'(horiz_ctrl[`FPICX_GFX_MSB:`FPICX_GFX_LSB]);
		text_v = fpicx_stretch_t'(vert_ctrl[`FPICX_TEXT_MSB:`FPICX_TEXT_LSB]);
		if (text_mode)
		begin
			general_on  = (text_h == FPICX_STRETCH_LIMITED) ||
			              (text_h == FPICX_STRETCH_FULL);
			general_cap = (text_h == FPICX_STRETCH_LIMITED);
		end
		else
		begin
			general_on  = (gfx_h == FPICX_STRETCH_LIMITED) ||
			              (gfx_h == FPICX_STRETCH_FULL);
			general_cap = (gfx_h == FPICX_STRETCH_LIMITED);
		end
	end

	always_comb
	begin
		mode_has_own = 1'b0;
		mode_own_bit = 1'b0;
		if (text_mode && narrow_text_mode)
		begin
			mode_has_own = 1'b1;
			mode_own_bit = horiz_modes[`FPICX_NARROW_TEXT_BIT];
		end
		else if (text_mode && wide_text_mode)
		begin
			mode_has_own = 1'b1;
			mode_own_bit = horiz_modes[`FPICX_WIDE_TEXT_BIT];
		end
		else if (!text_mode && low_res_gfx_mode)
		begin
			mode_has_own = 1'b1;
			mode_own_bit = horiz_modes[`FPICX_LOW_GFX_BIT];
		end
		else if (!text_mode && mid_res_gfx_mode)
		begin
			mode_has_own = 1'b1;
			mode_own_bit = horiz_modes[`FPICX_MID_GFX_BIT];
		end
		else if (!text_mode && high_res_gfx_mode)
		begin
			mode_has_own = 1'b1;
			mode_own_bit = horiz_modes[`FPICX_HIGH_GFX_BIT];
		end
	end

	// expansion outputs held in flops, settle one cycle after a change
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			horiz_stretch_on  <= 1'b0;
			horiz_stretch_cap <= 1'b0;
			horiz_center_on   <= 1'b0;
			force_8dot_text   <= 1'b0;
			line_gfx_on       <= 1'b0;
			ninth_dot_bg      <= 1'b1;
			vert_stretch_on   <= 1'b0;
			vert_stretch_cap  <= 1'b0;
		end
		else
		begin
			// per-mode bit gated by general field
			horiz_stretch_on  <= general_on && (!mode_has_own || mode_own_bit);
			horiz_stretch_cap <= general_on && general_cap &&
			                     (!mode_has_own || mode_own_bit);
			horiz_center_on   <= horiz_ctrl[`FPICX_HCENTER_BIT];
			// full text stretch on VGA panel
			force_8dot_text   <= vga_panel && text_mode &&
			                     (text_h == FPICX_STRETCH_FULL) &&
			                     (!mode_has_own || mode_own_bit);
			// line graphics or background ninth dot
			line_gfx_on       <= horiz_ctrl[`FPICX_LINEGFX_BIT];
			ninth_dot_bg      <= !horiz_ctrl[`FPICX_LINEGFX_BIT];
			vert_stretch_on   <= text_mode &&
			                     ((text_v == FPICX_STRETCH_LIMITED) ||
			                      (text_v == FPICX_STRETCH_FULL));
			vert_stretch_cap  <= text_mode &&
			                     (text_v == FPICX_STRETCH_LIMITED);
		end
	end

endmodule
`default_nettype wire

// *** test/fpicx_bank_chk.sv ***
// concurrent checks on the panel register bank ports
`timescale 1ns/1ps
`default_nettype none

module fpicx_bank_chk
(
	input wire logic       sys_clk,           // system clock
	input wire logic       rst,               // synchronous reset
	input wire logic       host_rd,           // read strobe
	input wire logic [7:0] host_rdata,        // read byte
	input wire logic       host_rdata_valid,  // read answer pulse
	input wire logic       mem_is_512kx32,    // memory type
	input wire logic       vga_panel,         // panel class
	input wire logic       text_mode,         // text frame
	input wire logic       mod_pin_out,       // modulated level
	input wire logic       mod_pin_oe,        // pin drive enable
	input wire logic       horiz_stretch_on,  // horizontal stretch
	input wire logic       horiz_stretch_cap, // horizontal cap
	input wire logic       force_8dot_text,   // 8-dot text
	input wire logic       line_gfx_on,       // line graphics
	input wire logic       ninth_dot_bg,      // ninth dot blank
	input wire logic       vert_stretch_on,   // vertical stretch
	input wire logic       vert_stretch_cap   // vertical cap
);
	// one domain, so clock and reset are given once
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	rd_answer_a: assert property (host_rd |=> host_rdata_valid)
		else $error("read answer missing");
	no_stray_a: assert property (!host_rd |=> !host_rdata_valid)
		else $error("read answer without request");
	rdata_hold_a: assert property (!host_rdata_valid |-> $stable(host_rdata))
		else $error("read byte moved between reads");
	oe_blocked_a: assert property (mem_is_512kx32 |-> !mod_pin_oe)
		else $error("pin driven on 512Kx32 memory");
	pin_quiet_a: assert property (!mod_pin_oe |=> !mod_pin_out)
		else $error("modulated level while not driving");
	hcap_on_a: assert property (horiz_stretch_cap |-> horiz_stretch_on)
		else $error("horizontal cap without stretch");
	vcap_on_a: assert property (vert_stretch_cap |-> vert_stretch_on)
		else $error("vertical cap without stretch");
	ninth_dot_a: assert property (line_gfx_on ^ ninth_dot_bg)
		else $error("line graphics and ninth dot disagree");
	eight_dot_a: assert property (force_8dot_text |-> $past(vga_panel))
		else $error("8-dot forced on non VGA panel");
	vert_text_a: assert property (vert_stretch_on |-> $past(text_mode))
		else $error("text vertical stretch outside text");
endmodule

bind fpicx_bank fpicx_bank_chk u_chk (.sys_clk, .rst, .host_rd, .host_rdata,
	.host_rdata_valid, .mem_is_512kx32, .vga_panel, .text_mode, .mod_pin_out,
	.mod_pin_oe, .horiz_stretch_on, .horiz_stretch_cap, .force_8dot_text,
	.line_gfx_on, .ninth_dot_bg, .vert_stretch_on, .vert_stretch_cap);

`default_nettype wire

// *** test/fpicx_clk_src.sv ***
// free-running reference and bus clock sources for the modulator
`timescale 1ns/1ps
`default_nettype none

module fpicx_clk_src
#(
	parameter int REF_HALF = 200, // reference half period, ns
	parameter int PCI_HALF = 300  // bus clock half period, ns
)
(
	output logic ref_clk_pin,     // reference clock pin
	output logic pci_clk_pin      // bus clock pin
);
	// both run free; kept slow so 20 MHz sampling tracks every edge
	initial ref_clk_pin = 1'b0;
	initial pci_clk_pin = 1'b1;
	always #REF_HALF ref_clk_pin = ~ref_clk_pin;
	always #PCI_HALF pci_clk_pin = ~pci_clk_pin;
endmodule

`default_nettype wire

// *** test/tb.sv ***
// self-checking bench for the panel register bank
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic        sys_clk, rst, host_port_sel, host_wr, host_rd;
	logic [7:0]  host_wdata, host_rdata, d;
	logic        host_rdata_valid, mem_is_4mb, mem_is_512kx32;
	logic [22:0] mem_top_addr, icon_map_addr, passive_data_start;
	logic [2:0]  icon_map_select;
	logic        ref_clk_pin, pci_clk_pin, text_mode, vga_panel;
	logic        narrow_text_mode, wide_text_mode, low_res_gfx_mode;
	logic        mid_res_gfx_mode, high_res_gfx_mode;
	logic [9:0]  icon_vert_pos;
	logic [15:0] passive_fb_size;
	logic        mod_pin_out, mod_pin_oe, horiz_stretch_on;
	logic        horiz_stretch_cap, horiz_center_on, force_8dot_text;
	logic        line_gfx_on, ninth_dot_bg, vert_stretch_on;
	logic        vert_stretch_cap;
	int          err_total, cmp_count, i, hi, per;
	// writable bits of 4Ch..56h; the rest must read as zero
	logic [7:0]  msk [11] = '{8'h03, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
		8'hFF, 8'h73, 8'hFF, 8'h9F, 8'h1F, 8'h1F};
	int          pre [4] = '{0, 1, 2, 4}; // prescale codes
	int          mul [4] = '{2, 3, 4, 6}; // twice the divisor

	fpicx_clk_src u_src (.ref_clk_pin, .pci_clk_pin);

	fpicx_bank #(.ICON_MAP_BYTES(1024), .SYNC_STAGES(3)) DUT (.sys_clk,
		.rst, .host_port_sel, .host_wr, .host_rd, .host_wdata,
		.host_rdata, .host_rdata_valid, .mem_is_4mb, .mem_is_512kx32,
		.mem_top_addr, .icon_map_select, .ref_clk_pin, .pci_clk_pin,
		.text_mode, .vga_panel, .narrow_text_mode, .wide_text_mode,
		.low_res_gfx_mode, .mid_res_gfx_mode, .high_res_gfx_mode,
		.icon_vert_pos, .icon_map_addr, .passive_data_start,
		.passive_fb_size, .mod_pin_out, .mod_pin_oe, .horiz_stretch_on,
		.horiz_stretch_cap, .horiz_center_on, .force_8dot_text,
		.line_gfx_on, .ninth_dot_bg, .vert_stretch_on, .vert_stretch_cap);

	// 20 MHz system clock
	initial sys_clk = 1'b0;
	always #25 sys_clk = ~sys_clk;

	// inputs move 1 ns after the rising edge, clear of sampling
	task tk;
		@(posedge sys_clk);
		#1;
	endtask

	task wrap_up;
		$display("errors %0d compares %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task chk_val(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error at %0t got %0h exp %0h", $time, got, exp);
		end
	endtask

	// one strobe on the index (0) or data (1) port
	task put(input logic s, input logic [7:0] v);
		tk;
		host_port_sel = s;
		host_wdata = v;
		host_wr = 1'b1;
		tk;
		host_wr = 1'b0;
	endtask

	// index write then data write; decoded outputs settle one edge later
	task wr(input logic [7:0] a, input logic [7:0] v);
		put(1'b0, a);
		put(1'b1, v);
		tk;
	endtask

	task rd(input logic [7:0] a, output logic [7:0] v);
		put(1'b0, a);
		tk;
		host_port_sel = 1'b1;
		host_rd = 1'b1;
		tk;
		host_rd = 1'b0;
		chk_val(host_rdata_valid, 1'b1);
		v = host_rdata;
	endtask

	// bounded wait while the pin holds level v
	task wt(input logic v, inout int n);
		while (mod_pin_out === v && n < 20000)
		begin
			tk;
			n++;
		end
	endtask

	// high time and period of one full modulation period
	task meas(output int h, output int p);
		int n;
		n = 0;
		wt(1'b1, n);
		wt(1'b0, n);
		h = 0;
		wt(1'b1, h);
		p = h;
		wt(1'b0, p);
	endtask

	// high samples over a span longer than one period
	task cnt(output int h);
		h = 0;
		repeat (4) tk;
		repeat (2200)
		begin
			tk;
			h += (mod_pin_out === 1'b1);
		end
	endtask

	// hang guard, well past the expected run length
	initial
	begin
		repeat (100000) @(posedge sys_clk);
		err_total++;
		wrap_up;
	end

	initial
	begin
		{rst, host_port_sel, host_wr, host_rd, host_wdata} = {1'b1, 11'h0};
		{mem_is_4mb, mem_is_512kx32, icon_map_select} = 5'h0;
		mem_top_addr = 23'h3FFFFF;
		{text_mode, vga_panel, narrow_text_mode, wide_text_mode} = 4'hC;
		{low_res_gfx_mode, mid_res_gfx_mode, high_res_gfx_mode} = 3'h0;
		repeat (12) tk;
		rst = 1'b0;
		// reset values, then reserved bits dropped, unmapped index dead
		for (i = 0; i < 11; i++)
		begin
			rd(8'h4C + i[7:0], d);
			chk_val(d, 8'h00);
			wr(8'h4C + i[7:0], 8'hFF);
			rd(8'h4C + i[7:0], d);
			chk_val(d, msk[i]);
		end
		wr(8'h57, 8'hFF);
		rd(8'h57, d);
		chk_val(d, 8'h00);
		// geometry outputs
		wr(8'h4C, 8'h02);
		wr(8'h4D, 8'h5A);
		chk_val(icon_vert_pos, 10'h25A);
		icon_map_select = 3'h3;
		wr(8'h4E, 8'h05);
		chk_val(icon_map_addr, 23'h00AC00);
		mem_is_4mb = 1'b1;
		repeat (2) tk;
		chk_val(icon_map_addr, 23'h20AC00);
		wr(8'h4F, 8'h03);
		chk_val(passive_data_start, 23'h3F9FFF);
		per = ((640 * 3 + 63) / 64) * (480 / 2);
		wr(8'h50, per[7:0]);
		wr(8'h51, per[15:8]);
		chk_val(passive_fb_size, per[15:0]);
		// modulator: pin ownership, then period per prescale and duty at divide-by-1
		mem_is_512kx32 = 1'b1;
		wr(8'h53, 8'h40);
		wr(8'h52, 8'h01);
		chk_val(mod_pin_oe, 1'b0);
		mem_is_512kx32 = 1'b0;
		tk;
		chk_val(mod_pin_oe, 1'b1);
		for (i = 0; i < 4; i++)
		begin
			wr(8'h52, 8'h01 | (pre[i][7:0] << 4));
			meas(hi, per);
			chk_val(per, 1024 * mul[i]);
			if (i == 0)
				chk_val(hi, 512);
		end
		wr(8'h52, 8'h03);
		meas(hi, per);
		chk_val(per, 3072);
		wr(8'h52, 8'h31);
		cnt(hi);
		chk_val(hi % 2200, 0);
		wr(8'h52, 8'h01);
		wr(8'h53, 8'hFF);
		cnt(hi);
		chk_val(hi, 2200);
		wr(8'h53, 8'h00);
		cnt(hi);
		chk_val(hi, 0);
		wr(8'h53, 8'hFF);
		wr(8'h52, 8'h00);
		cnt(hi);
		chk_val({mod_pin_oe, hi[11:0]}, 13'h0);
		// stretch fields over every code, text then graphics
		wide_text_mode = 1'b1;
		wr(8'h55, 8'h02);
		for (i = 0; i < 4; i++)
		begin
			wr(8'h54, i[7:0]);
			chk_val({horiz_stretch_on, horiz_stretch_cap, force_8dot_text},
				{i[0], i == 1, i == 3});
			wr(8'h56, i[7:0]);
			chk_val({vert_stretch_on, vert_stretch_cap},
				{i[0], i == 1});
		end
		vga_panel = 1'b0;
		tk;
		chk_val(force_8dot_text, 1'b0);
		wr(8'h55, 8'h01);
		chk_val(horiz_stretch_on, 1'b0);
		{wide_text_mode, narrow_text_mode} = 2'h1;
		tk;
		chk_val(horiz_stretch_on, 1'b1);
		{text_mode, wide_text_mode, mid_res_gfx_mode} = 3'h1;
		wr(8'h55, 8'h08);
		for (i = 0; i < 4; i++)
		begin
			wr(8'h54, i[7:0] << 2);
			chk_val({horiz_stretch_on, horiz_stretch_cap},
				{i[0], i == 1});
		end
		{mid_res_gfx_mode, high_res_gfx_mode} = 2'h1;
		wr(8'h54, 8'h0C);
		chk_val(horiz_stretch_on, 1'b0);
		wr(8'h55, 8'h10);
		chk_val(horiz_stretch_on, 1'b1);
		{high_res_gfx_mode, low_res_gfx_mode} = 2'h1;
		tk;
		chk_val(horiz_stretch_on, 1'b0);
		wr(8'h55, 8'h04);
		chk_val(horiz_stretch_on, 1'b1);
		wr(8'h54, 8'h03);
		chk_val(horiz_stretch_on, 1'b0);
		wr(8'h54, 8'h90);
		chk_val({horiz_center_on, line_gfx_on, ninth_dot_bg}, 3'h6);
		wr(8'h54, 8'h00);
		chk_val({horiz_center_on, line_gfx_on, ninth_dot_bg}, 3'h1);
		wrap_up;
	end
endmodule

`default_nettype wire
